// *** iot_defs.svh ***
`ifndef IOT_DEFS_SVH
`define IOT_DEFS_SVH
// Analog scales: volts in 10 mV units, settings in 0.1 % units
`define IOT_AI_FULL_CV    16'h03E8
`define IOT_PCT_FULL      16'h03E8
`define IOT_AO_FULL_CV    32'h000003E8
// Filter timing: one time-constant unit is 100 ms
`define IOT_CLK_KHZ       125000
`define IOT_FILT_UNIT_MS  100
`define IOT_FILT_SHIFT    10
`define IOT_FILT_STEP_CYC ((`IOT_FILT_UNIT_MS * `IOT_CLK_KHZ) >> `IOT_FILT_SHIFT)
`define IOT_TC_MIN        6'h01
`define IOT_TC_MAX        6'h32
// Reset values of the configuration
`define IOT_TC_DEF        6'h01
`define IOT_BAND_DEF      16'h000A
`define IOT_AI_LO_DEF     16'h0000
`define IOT_AI_HI_DEF     16'h03E8
`define IOT_SET_LO_DEF    16'h0000
`define IOT_SET_HI_DEF    16'h03E8
`define IOT_AO_SEL_DEF    3'h0
`define IOT_AO_LO_DEF     16'h0000
`define IOT_AO_HI_DEF     16'h03E8
`define IOT_FN_DEF1       5'h03
`define IOT_FN_DEF2       5'h04
`define IOT_FN_DEF3       5'h00
`define IOT_FN_DEF4       5'h00
`define IOT_FN_DEF5       5'h00
// Terminal function codes
`define IOT_FN_JOG_FWD    5'h01
`define IOT_FN_JOG_REV    5'h02
`define IOT_FN_RUN_FWD    5'h03
`define IOT_FN_RUN_REV    5'h04
`define IOT_FN_COAST      5'h06
`define IOT_FN_DECEL      5'h07
`define IOT_FN_RESET      5'h08
`define IOT_FN_EXT_FAULT  5'h09
`define IOT_FN_FREQ_UP    5'h0A
`define IOT_FN_FREQ_DN    5'h0B
`define IOT_FN_SPD_B0     5'h0D
`define IOT_FN_SPD_B1     5'h0E
`define IOT_FN_SPD_B2     5'h0F
`define IOT_FN_FORCE_TERM 5'h10
`define IOT_FN_FORCE_COMM 5'h11
`define IOT_FN_DC_BRAKE   5'h12
`define IOT_FN_SRC_AI     5'h13
`define IOT_FN_SRC_DIG1   5'h14
`define IOT_FN_SRC_DIG2   5'h15
`define IOT_FN_CNT_CLR    5'h17
`define IOT_FN_CNT_TRIG   5'h18
// Command and frequency source codes
`define IOT_CSRC_TERM     2'h1
`define IOT_CSRC_COMM     2'h2
`define IOT_FSRC_DIG1     3'h0
`define IOT_FSRC_UPDOWN   3'h1
`define IOT_FSRC_AI       3'h2
// Analog output selector codes
`define IOT_AO_FREQ       3'h0
`define IOT_AO_CUR        3'h1
`define IOT_AO_SPEED      3'h2
`define IOT_AO_VOLT       3'h3
`define IOT_AO_AIN        3'h4
`endif

// *** iot_pkg.sv ***
package iot_pkg;
    // Configuration set, loaded as a whole
    typedef struct packed {
        logic [15:0]       ai_lo_cv;
        logic [15:0]       ai_hi_cv;
        logic signed [15:0] ai_set_lo;
        logic signed [15:0] ai_set_hi;
        logic [5:0]        filt_tc;
        logic [15:0]       dev_band_cv;
        logic [2:0]        ao_sel;
        logic [15:0]       ao_lo_cv;
        logic [15:0]       ao_hi_cv;
        logic [4:0][4:0]   func_sel;
    } iot_cfg_t;
    // Drive quantities for the analog output
    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] max_freq;
        logic [15:0] out_cur;
        logic [15:0] rated_cur;
        logic [15:0] mot_speed;
        logic [15:0] sync_speed;
        logic [15:0] out_volt;
        logic [15:0] rated_volt;
    } iot_drive_t;
    // Decoded terminal commands
    typedef struct packed {
        logic       jog_fwd;
        logic       jog_rev;
        logic       forward_run_cmd;
        logic       reverse_run_cmd;
        logic       coast_stop;
        logic       decel_stop;
        logic       fault_reset;
        logic       freq_up;
        logic       freq_down;
        logic       dc_brake;
        logic [2:0] speed_stage;
        logic [1:0] eff_cmd_src;
        logic [2:0] eff_freq_src;
    } iot_cmd_t;
endpackage : iot_pkg

// *** iot_top.sv ***
`timescale 1ns/10ps
`include "iot_defs.svh"
module iot_top
    import iot_pkg::*;
#(
    parameter int unsigned FILT_STEP_CYC = `IOT_FILT_STEP_CYC
)
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Configuration
    input  wire logic               cfg_load,
    input  wire iot_cfg_t           cfg_in,
    output iot_cfg_t                cfg_rd,
    // Analog input samples, 10 mV units
    input  wire logic [15:0]        analog_in,
    input  wire logic               analog_in_valid,
    output logic [15:0]             ai_hold_cv,
    output logic signed [15:0]      ai_setting,
    // Analog output
    input  wire iot_drive_t         drive,
    output logic [15:0]             analog_out,
    // Terminals, low when shorted to ground
    input  wire logic               input_pin_1_n,
    input  wire logic               input_pin_2_n,
    input  wire logic               input_pin_3_n,
    input  wire logic               input_pin_4_n,
    input  wire logic               input_pin_5_n,
    // Drive context
    input  wire logic [1:0]         cmd_src,
    input  wire logic [2:0]         freq_src,
    input  wire logic               panel_fault_clear,
    input  wire logic               count_down,
    // Results
    output iot_cmd_t                cmd,
    output logic                    external_fault_alarm,
    output logic [15:0]             counter_value
);

    // True when any terminal assigned the code is active
    function automatic logic fn_on(input logic [4:0][4:0] sel, input logic [4:0] act, input logic [4:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 5; i++)
            r = r | (act[i] && sel[i] == code);
        return r;
    endfunction : fn_on

    // Quotient saturated to 16 bits; a zero divisor reads as zero
    function automatic logic [15:0] sat_div(input logic [47:0] num, input logic [31:0] den);
        logic [47:0] q;
        q = 48'h0;
        if (den != 32'h0)
            q = num / {16'h0, den};
        return (q > 48'h00000000FFFF) ? 16'hFFFF : q[15:0];
    endfunction : sat_div

    iot_cfg_t            cfg_r;
    logic [15:0]         samp_r;
    logic [20:0]         filt_r;
    logic [19:0]         step_cnt_r;
    logic [15:0]         hold_r;
    logic signed [15:0]  set_r;
    logic [15:0]         ao_r;
    logic [4:0]          pin_s1_r;
    logic [4:0]          pin_s2_r;
    logic [4:0]          act_prev_r;
    iot_cmd_t            cmd_r;
    logic                ext_fault_r;
    logic [15:0]         cnt_r;

    // Configuration store; selector defaults give forward and reverse run on pins 1 and 2
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfg_r <= '{`IOT_AI_LO_DEF, `IOT_AI_HI_DEF, `IOT_SET_LO_DEF, `IOT_SET_HI_DEF, `IOT_TC_DEF,
                       `IOT_BAND_DEF, `IOT_AO_SEL_DEF, `IOT_AO_LO_DEF, `IOT_AO_HI_DEF,
                       {`IOT_FN_DEF5, `IOT_FN_DEF4, `IOT_FN_DEF3, `IOT_FN_DEF2, `IOT_FN_DEF1}};
        end
        else if (cfg_load)
        begin
            cfg_r <= cfg_in;
        end
    end

    // Time constant limited to its legal span so a bad load cannot stall the filter
    logic [5:0]  tc_c;
    logic [19:0] step_lim_c;
    logic        step_hit_c;
    assign tc_c       = (cfg_r.filt_tc < `IOT_TC_MIN) ? `IOT_TC_MIN :
                        (cfg_r.filt_tc > `IOT_TC_MAX) ? `IOT_TC_MAX : cfg_r.filt_tc;
    assign step_lim_c = 20'(32'(tc_c) * FILT_STEP_CYC);
    assign step_hit_c = (step_cnt_r >= step_lim_c - 20'h1);

    // Latest sample, limited to full scale
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            samp_r <= 16'h0000;
        else if (analog_in_valid)
            samp_r <= (analog_in > `IOT_AI_FULL_CV) ? `IOT_AI_FULL_CV : analog_in;
    end

    // First-order filter: 2^10 steps per time constant, step period scales with it
    logic signed [21:0] diff_c;
    logic [15:0]        filt_cv_c;
    assign diff_c    = $signed({1'b0, samp_r[10:0], 10'h000}) - $signed({1'b0, filt_r});
    assign filt_cv_c = {5'h00, 11'((filt_r + 21'h000200) >> `IOT_FILT_SHIFT)};
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            step_cnt_r <= 20'h00000;
            filt_r     <= 21'h000000;
        end
        else if (step_hit_c)
        begin
            step_cnt_r <= 20'h00000;
            filt_r     <= 21'($signed({1'b0, filt_r}) + ((diff_c + 22'sh000200) >>> `IOT_FILT_SHIFT));
        end
        else
        begin
            step_cnt_r <= step_cnt_r + 20'h1;
        end
    end

    // Deviation band: a jitter of less than the band leaves the held value alone
    logic [15:0] absdiff_c;
    assign absdiff_c = (filt_cv_c >= hold_r) ? filt_cv_c - hold_r : hold_r - filt_cv_c;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            hold_r <= 16'h0000;
        else if (absdiff_c >= cfg_r.dev_band_cv)
            hold_r <= filt_cv_c;
    end

    // Linear map of the held voltage onto the percentage span
    logic [15:0]        hc_c;
    logic signed [33:0] num_c;
    logic signed [33:0] map_c;
    always_comb
    begin
        hc_c  = (hold_r < cfg_r.ai_lo_cv) ? cfg_r.ai_lo_cv :
                (hold_r > cfg_r.ai_hi_cv) ? cfg_r.ai_hi_cv : hold_r;
        num_c = 34'($signed({1'b0, hc_c - cfg_r.ai_lo_cv})) * 34'(cfg_r.ai_set_hi - cfg_r.ai_set_lo);
        map_c = 34'(cfg_r.ai_set_lo);
        if (cfg_r.ai_hi_cv > cfg_r.ai_lo_cv)
            map_c = map_c + num_c / $signed({18'h0, cfg_r.ai_hi_cv - cfg_r.ai_lo_cv});
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            set_r <= 16'sh0000;
        else
            set_r <= 16'(map_c);
    end

    // Output source scaled to 0..10.00 V of its full range
    logic [15:0] src_c;
    logic [15:0] ao_c;
    always_comb
    begin
        unique case (cfg_r.ao_sel)
            `IOT_AO_FREQ:  src_c = sat_div(48'(drive.out_freq) * `IOT_AO_FULL_CV, 32'(drive.max_freq));
            `IOT_AO_CUR:   src_c = sat_div(48'(drive.out_cur) * `IOT_AO_FULL_CV, 32'(drive.rated_cur) * 32'h2);
            `IOT_AO_SPEED: src_c = sat_div(48'(drive.mot_speed) * `IOT_AO_FULL_CV, 32'(drive.sync_speed));
            `IOT_AO_VOLT:  src_c = sat_div(48'(drive.out_volt) * `IOT_AO_FULL_CV * 48'h5,
                                           32'(drive.rated_volt) * 32'h6);
            `IOT_AO_AIN:   src_c = hold_r;
            default:       src_c = 16'h0000; // Reserved codes drive the lower limit
        endcase
        ao_c = (src_c < cfg_r.ao_lo_cv) ? cfg_r.ao_lo_cv :
               (src_c > cfg_r.ao_hi_cv) ? cfg_r.ao_hi_cv : src_c;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ao_r <= `IOT_AO_LO_DEF;
        else
            ao_r <= ao_c;
    end

    // Two-stage synchroniser; only the second stage feeds decoding
    logic [4:0] act_c;
    assign act_c = ~pin_s2_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r   <= 5'h1F;
            pin_s2_r   <= 5'h1F;
            act_prev_r <= 5'h00;
        end
        else
        begin
            pin_s1_r   <= {input_pin_5_n, input_pin_4_n, input_pin_3_n, input_pin_2_n, input_pin_1_n};
            pin_s2_r   <= pin_s1_r;
            act_prev_r <= act_c;
        end
    end

    // Per-function levels and edges
    logic on_term_c, on_comm_c, eff_term_c, rst_edge_c, trig_edge_c, clr_c, on_fault_c;
    logic [1:0] eff_src_c;
    logic [2:0] eff_fsrc_c;
    assign on_term_c   = fn_on(cfg_r.func_sel, act_c, `IOT_FN_FORCE_TERM);
    assign on_comm_c   = fn_on(cfg_r.func_sel, act_c, `IOT_FN_FORCE_COMM);
    // Forcing is a pure override, so the stored source returns by itself on release
    assign eff_src_c   = on_term_c ? `IOT_CSRC_TERM : (on_comm_c ? `IOT_CSRC_COMM : cmd_src);
    assign eff_term_c  = (eff_src_c == `IOT_CSRC_TERM);
    assign eff_fsrc_c  = fn_on(cfg_r.func_sel, act_c, `IOT_FN_SRC_AI)   ? `IOT_FSRC_AI :
                         fn_on(cfg_r.func_sel, act_c, `IOT_FN_SRC_DIG1) ? `IOT_FSRC_DIG1 :
                         fn_on(cfg_r.func_sel, act_c, `IOT_FN_SRC_DIG2) ? `IOT_FSRC_UPDOWN : freq_src;
    assign rst_edge_c  = fn_on(cfg_r.func_sel, act_c, `IOT_FN_RESET) &&
                         !fn_on(cfg_r.func_sel, act_prev_r, `IOT_FN_RESET);
    assign trig_edge_c = fn_on(cfg_r.func_sel, act_c, `IOT_FN_CNT_TRIG) &&
                         !fn_on(cfg_r.func_sel, act_prev_r, `IOT_FN_CNT_TRIG);
    assign clr_c       = fn_on(cfg_r.func_sel, act_c, `IOT_FN_CNT_CLR);
    assign on_fault_c  = fn_on(cfg_r.func_sel, act_c, `IOT_FN_EXT_FAULT);

    // Registered command word
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cmd_r <= '0;
        else
        begin
            cmd_r.jog_fwd         <= eff_term_c && fn_on(cfg_r.func_sel, act_c, `IOT_FN_JOG_FWD);
            cmd_r.jog_rev         <= eff_term_c && fn_on(cfg_r.func_sel, act_c, `IOT_FN_JOG_REV);
            cmd_r.forward_run_cmd <= eff_term_c && fn_on(cfg_r.func_sel, act_c, `IOT_FN_RUN_FWD);
            cmd_r.reverse_run_cmd <= eff_term_c && fn_on(cfg_r.func_sel, act_c, `IOT_FN_RUN_REV);
            cmd_r.coast_stop      <= fn_on(cfg_r.func_sel, act_c, `IOT_FN_COAST);
            cmd_r.decel_stop      <= fn_on(cfg_r.func_sel, act_c, `IOT_FN_DECEL);
            cmd_r.fault_reset     <= rst_edge_c;
            cmd_r.freq_up         <= (eff_fsrc_c == `IOT_FSRC_UPDOWN) &&
                                     fn_on(cfg_r.func_sel, act_c, `IOT_FN_FREQ_UP);
            cmd_r.freq_down       <= (eff_fsrc_c == `IOT_FSRC_UPDOWN) &&
                                     fn_on(cfg_r.func_sel, act_c, `IOT_FN_FREQ_DN);
            cmd_r.dc_brake        <= fn_on(cfg_r.func_sel, act_c, `IOT_FN_DC_BRAKE);
            cmd_r.speed_stage     <= {fn_on(cfg_r.func_sel, act_c, `IOT_FN_SPD_B2),
                                      fn_on(cfg_r.func_sel, act_c, `IOT_FN_SPD_B1),
                                      fn_on(cfg_r.func_sel, act_c, `IOT_FN_SPD_B0)};
            cmd_r.eff_cmd_src     <= eff_src_c;
            cmd_r.eff_freq_src    <= eff_fsrc_c;
        end
    end

    // External fault latch; a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ext_fault_r <= 1'b0;
        else if (on_fault_c)
            ext_fault_r <= 1'b1;
        else if (rst_edge_c || panel_fault_clear)
            ext_fault_r <= 1'b0;
    end

    // Event counter; a held clear beats a pulse, pulses are slow so no debounce
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_r <= 16'h0000;
        else if (clr_c)
            cnt_r <= 16'h0000;
        else if (trig_edge_c)
            cnt_r <= count_down ? cnt_r - 16'h1 : cnt_r + 16'h1;
    end

    assign cfg_rd               = cfg_r;
    assign ai_hold_cv           = hold_r;
    assign ai_setting           = set_r;
    assign analog_out           = ao_r;
    assign cmd                  = cmd_r;
    assign external_fault_alarm = ext_fault_r;
    assign counter_value        = cnt_r;

    // Checks
    filt_step_a: assert property (@(posedge clk_sys) disable iff (rst)
        filt_r != $past(filt_r) |-> $past(step_hit_c)) else $error("filter moved off step");
    band_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        hold_r != $past(hold_r) |-> $past(absdiff_c >= cfg_r.dev_band_cv)) else $error("band ignored");
    map_low_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(cfg_r.ai_hi_cv > cfg_r.ai_lo_cv && hold_r <= cfg_r.ai_lo_cv)
        |-> set_r == $past(cfg_r.ai_set_lo)) else $error("low end not mapped");
    ao_clamp_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(cfg_r.ao_lo_cv <= cfg_r.ao_hi_cv)
        |-> ao_r >= $past(cfg_r.ao_lo_cv) && ao_r <= $past(cfg_r.ao_hi_cv)) else $error("output not clamped");
    run_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_r.forward_run_cmd || cmd_r.reverse_run_cmd |-> $past(eff_term_c)) else $error("run off terminal");
    jog_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_r.jog_fwd || cmd_r.jog_rev |-> cmd_r.eff_cmd_src == `IOT_CSRC_TERM) else $error("jog off terminal");
    force_src_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(on_comm_c && !on_term_c) |-> cmd_r.eff_cmd_src == `IOT_CSRC_COMM) else $error("force lost");
    fault_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
        on_fault_c |=> ext_fault_r) else $error("fault not latched");
    reset_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_r.fault_reset |=> !cmd_r.fault_reset) else $error("reset not a pulse");
    count_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
        clr_c |=> cnt_r == 16'h0000) else $error("counter not cleared");
    pin_sync_a: assert property (@(posedge clk_sys) disable iff (rst)
        !input_pin_1_n [*3] |-> act_c[0]) else $error("pin not asserted");
    cover_run_c: cover property (@(posedge clk_sys) disable iff (rst) cmd_r.forward_run_cmd);
    cover_fault_c: cover property (@(posedge clk_sys) disable iff (rst) ext_fault_r ##[1:50] !ext_fault_r);
    cover_hold_c: cover property (@(posedge clk_sys) disable iff (rst) hold_r != $past(hold_r));
    cover_count_c: cover property (@(posedge clk_sys) disable iff (rst) trig_edge_c ##1 cnt_r != 16'h0000);

endmodule : iot_top

// *** iot_contacts.sv ***
`timescale 1ns/10ps
// Switch contacts on the terminals and a sampled analog source
module iot_contacts
    import iot_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Contact state and source level asked for by the bench
    input  wire logic [4:0]  closed,
    input  wire logic [15:0] level,
    // Terminals and sample stream
    output logic [4:0]       pin_n,
    output logic [15:0]      analog_in,
    output logic             analog_in_valid
);
    logic [2:0] div_r = 3'h0;

    // An open contact floats to the pull-up, a closed one shorts to ground
    assign pin_n = ~closed;

    // One sample in eight cycles; between samples the bus carries junk, not the old value
    always_ff @(negedge clk_sys)
    begin
        div_r           <= div_r + 3'h1;
        analog_in_valid <= (div_r == 3'h0);
        analog_in       <= (div_r == 3'h0) ? level : ~level;
    end
endmodule : iot_contacts

// *** test_io_terminal_function_logic.sv ***
`timescale 1ns/10ps
// Self-checking bench for the terminal decoder and the analog paths
module test_io_terminal_function_logic
    import iot_pkg::*;
;
    logic               clk_sys = 1'b0;
    logic               rst, cfg_load, analog_in_valid, panel_fault_clear, count_down, external_fault_alarm;
    iot_cfg_t           cfg_in, cfg_rd, cfg_r;
    iot_drive_t         drive;
    iot_cmd_t           cmd;
    logic [15:0]        analog_in, ai_hold_cv, analog_out, counter_value, level, h, e;
    logic signed [15:0] ai_setting;
    logic [4:0]         pin_n, closed;
    logic [1:0]         cmd_src;
    logic [2:0]         freq_src;
    logic [31:0]        seed = 32'h00000059;
    int                 num_errors = 0, n_compared = 0, n_pulse = 0, k, p, n;
    int                 fn_codes [9] = '{1, 2, 3, 4, 6, 7, 10, 11, 18};

    // Clock of 8 ns
    always #4 clk_sys = ~clk_sys;

    // Small filter step keeps the settling time short
    iot_top #(.FILT_STEP_CYC(4)) DUT (.clk_sys(clk_sys), .rst(rst), .cfg_load(cfg_load), .cfg_in(cfg_in),
        .cfg_rd(cfg_rd), .analog_in(analog_in), .analog_in_valid(analog_in_valid), .ai_hold_cv(ai_hold_cv),
        .ai_setting(ai_setting), .drive(drive), .analog_out(analog_out), .input_pin_1_n(pin_n[0]),
        .input_pin_2_n(pin_n[1]), .input_pin_3_n(pin_n[2]), .input_pin_4_n(pin_n[3]), .input_pin_5_n(pin_n[4]),
        .cmd_src(cmd_src), .freq_src(freq_src), .panel_fault_clear(panel_fault_clear), .count_down(count_down),
        .cmd(cmd), .external_fault_alarm(external_fault_alarm), .counter_value(counter_value));

    iot_contacts partner (.clk_sys(clk_sys), .closed(closed), .level(level), .pin_n(pin_n),
        .analog_in(analog_in), .analog_in_valid(analog_in_valid));

    // Counts reset pulses; a one-cycle pulse is easy to miss by polling
    always @(negedge clk_sys)
        if (cmd.fault_reset === 1'b1)
            n_pulse <= n_pulse + 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] clp(input logic [15:0] v, lo, hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : clp

    task automatic chk(input logic [15:0] x, input logic [15:0] g);
        n_compared++;
        if (g !== x)
        begin
            $display("BAD t=%0t exp=%h got=%h", $time, x, g);
            num_errors++;
        end
    endtask : chk

    task automatic wt(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : wt

    task automatic ld();
        cfg_in   = cfg_r;
        cfg_load = 1'b1;
        wt(1);
        cfg_load = 1'b0;
        wt(2);
    endtask : ld

    task automatic fns(input logic [24:0] f);
        cfg_r.func_sel = f;
        ld();
    endtask : fns

    task automatic pls();
        closed = 5'h01;
        wt(3);
        closed = 5'h00;
        wt(3);
    endtask : pls

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // Cuts a hang short well beyond the expected run of about 50500 cycles
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        {cfg_load, panel_fault_clear, count_down, closed, cmd_src, freq_src} = '0;
        cfg_in = '0;
        level  = 16'h0000;
        drive  = '{16'h00FA, 16'h01F4, 16'h0032, 16'h0064, 16'h0064, 16'h00C8, 16'h003C, 16'h0064};
        rst    = 1'b1;
        wt(16);
        rst = 1'b0;
        wt(1);
        chk(16'h0083, 16'(cfg_rd.func_sel));
        chk(16'h0000, 16'(cfg_rd.func_sel[4:3]));
        chk(16'h0001, 16'(cfg_rd.filt_tc));
        chk(16'h000A, cfg_rd.dev_band_cv);
        cfg_r = '{16'h0000, 16'h03E8, 16'hFC18, 16'h03E8, 6'h01, 16'h000A, 3'h0, 16'h0000, 16'h03E8, 25'h0};
        ld();
        // Analog input: settle, map, then a change inside the band
        level = 16'(500 + rnd() % 400);
        wt(30000);
        h = ai_hold_cv;
        chk(16'h0001, 16'(h <= level + 10 && h + 10 >= level));
        chk(16'(2 * h - 1000), ai_setting);
        level = h + 16'h0005;
        wt(20000);
        chk(h, ai_hold_cv);
        // Analog output over selector codes 0 to 5, open limits and then narrow ones
        for (int s = 0; s < 12; s++)
        begin
            cfg_r.ao_sel   = 3'(s % 6);
            cfg_r.ao_lo_cv = (s < 6) ? 16'h0000 : 16'h012C;
            cfg_r.ao_hi_cv = (s < 6) ? 16'h03E8 : 16'h0190;
            ld();
            e = (s % 6 == 1) ? 16'h00FA : (s % 6 == 4) ? h : (s % 6 == 5) ? 16'h0000 : 16'h01F4;
            chk(clp(e, cfg_r.ao_lo_cv, cfg_r.ao_hi_cv), analog_out);
        end
        // Level commands on a random pin, gated by random sources
        for (int r = 0; r < 18; r++)
        begin
            k        = r % 9;
            p        = rnd() % 5;
            // First pass with the gating sources on, second pass with them off
            cmd_src  = (r < 9) ? 2'h1 : 2'(rnd() % 3) + 2'h2;
            freq_src = (r < 9) ? 3'h1 : 3'(rnd() % 2) * 3'h2;
            fns(25'(fn_codes[k]) << (p * 5));
            closed = 5'h01 << p;
            wt(4);
            e = ((k < 4) ? (cmd_src == 2'h1) : (k > 5 && k < 8) ? (freq_src == 3'h1) : 1'b1) ?
                (16'h0200 >> ((k < 6) ? k : k + 1)) : 16'h0000;
            chk(e, 16'(cmd[17:8]));
            closed = 5'h00;
            wt(4);
            chk(16'h0000, 16'(cmd[17:8]));
        end
        // Forced command source and frequency source switches, every pattern
        fns({5'h15, 5'h14, 5'h13, 5'h11, 5'h10});
        for (int v = 0; v < 32; v++)
        begin
            cmd_src  = 2'(rnd());
            freq_src = 3'(rnd() % 3);
            closed   = 5'(v);
            wt(4);
            chk(16'(closed[0] ? 2'h1 : closed[1] ? 2'h2 : cmd_src), 16'(cmd.eff_cmd_src));
            e = 16'(closed[2] ? 3'h2 : closed[3] ? 3'h0 : closed[4] ? 3'h1 : freq_src);
            chk(e, 16'(cmd.eff_freq_src));
        end
        // Speed stage index
        fns({5'h00, 5'h00, 5'h0F, 5'h0E, 5'h0D});
        for (int v = 0; v < 10; v++)
        begin
            closed = 5'(rnd());
            wt(4);
            chk(16'(closed[2:0]), 16'(cmd.speed_stage));
        end
        // External fault latched, cleared by terminal reset and by the panel
        fns({15'h0, 5'h08, 5'h09});
        n = n_pulse;
        for (int t = 0; t < 2; t++)
        begin
            pls();
            chk(16'h0001, 16'(external_fault_alarm));
            closed            = (t == 0) ? 5'h02 : 5'h00;
            panel_fault_clear = (t == 1);
            wt(4);
            chk(16'h0000, 16'(external_fault_alarm));
            {closed, panel_fault_clear} = '0;
            wt(4);
        end
        chk(16'(n + 1), 16'(n_pulse));
        // Counter: clear, random count up, then down
        fns({15'h0, 5'h17, 5'h18});
        closed = 5'h02;
        wt(4);
        chk(16'h0000, counter_value);
        closed = 5'h00;
        wt(2);
        n = 3 + rnd() % 8;
        repeat (n) pls();
        chk(16'(n), counter_value);
        count_down = 1'b1;
        repeat (2) pls();
        chk(16'(n - 2), counter_value);
        // Clear and a trigger edge together: the clear must win
        closed = 5'h03;
        wt(4);
        chk(16'h0000, counter_value);
        closed = 5'h00;
        wt(2);
        stop_test();
    end
endmodule : test_io_terminal_function_logic
